// ==== rtl/power_reset_pkg.sv ====
// Constants and types shared by the module power and reset control logic.
// Summary of operation
// [R1] A falling edge on the power button input produces a one-cycle button event.
// [R2] Button events wake the system from off or suspend and power a running one down.
// [R3] A low reset button input requests a reset and reboot of the module.
// [R4] The carrier drives the reset button with a clean falling edge.
// [R5] Dropping power-good or cycling power always recovers a stuck module.
// [R6] An active-low reset output resets carrier peripherals with the module.
// [R7] Carrier reset asserts on reset button, power-good, low supply, watchdog or software.
// [R8] Power-good high means main power valid; low means not yet valid.
// [R9] Startup waits until power-good is high; the carrier may hold it low.
// [R10] Pin inputs are synchronised before edge detection; reset holds while any source acts.
// [R11] An active-low output warns bus devices before a suspend takes effect.
package power_reset_pkg;

    typedef enum logic [1:0] {
        PWR_OFF,
        PWR_STARTUP,
        PWR_RUNNING,
        PWR_SUSPEND
    } power_state_type;

    // Synchroniser depth for pin inputs.
    localparam int SYNC_STAGES = 3;

    // Least time the carrier reset stands after its last source clears, in ns.
    localparam int RESET_HOLD_NS = 1000;
    localparam int CLOCK_PERIOD_NS = 50;
    localparam int RESET_HOLD_CYCLES = (RESET_HOLD_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

    // Least time the suspend warning leads the suspend itself, in ns.
    localparam int SUSPEND_LEAD_NS = 500;
    localparam int SUSPEND_LEAD_CYCLES =
        (SUSPEND_LEAD_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

    localparam int COUNT_WIDTH = 8;

endpackage : power_reset_pkg

// ==== rtl/pin_synchronizer.sv ====
// Three-stage synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ps
module pin_synchronizer #(
    parameter logic RESET_LEVEL = 1'b1
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic pinIn,
    output logic pinOut,
    output logic pinFall
);
    logic [power_reset_pkg::SYNC_STAGES-1:0] stages;
    logic settled;
    wire agree = (stages[1] == stages[2]);
    wire next_settled = agree ? stages[2] : settled;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            stages <= {power_reset_pkg::SYNC_STAGES{RESET_LEVEL}};
            settled <= RESET_LEVEL;
            pinFall <= 1'b0;
        end else begin
            stages <= {stages[1:0], pinIn};
            settled <= next_settled;
            pinFall <= settled & ~next_settled; // [R10]
        end
    end

    assign pinOut = settled;
endmodule : pin_synchronizer

// ==== rtl/module_power_reset_control.sv ====
// Power button, reset button and power-good handling with the carrier reset output.
`timescale 1ns/1ps
module module_power_reset_control #(
    parameter int HOLD_CYCLES = power_reset_pkg::RESET_HOLD_CYCLES,
    parameter int LEAD_CYCLES = power_reset_pkg::SUSPEND_LEAD_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic power_button_n,
    input wire logic reset_button_n,
    input wire logic power_good,
    input wire logic main_supply_input,
    input wire logic watchdog_timeout,
    input wire logic software_reset,
    input wire logic suspend_request,
    output logic power_button_event,
    output logic carrier_reset_out_n,
    output logic suspend_imminent_n,
    output logic system_running,
    output logic system_suspended
);
    localparam int CW = power_reset_pkg::COUNT_WIDTH;
    localparam logic [CW-1:0] HOLD_COUNT = CW'(HOLD_CYCLES);
    localparam logic [CW-1:0] LEAD_COUNT = CW'(LEAD_CYCLES);
    localparam logic [CW-1:0] ZERO_COUNT = 8'h00;
    localparam logic [CW-1:0] ONE_COUNT = 8'h01;
    localparam logic [CW-1:0] FULL_COUNT = 8'hFF;

    // Counters step down by one and rest at zero instead of wrapping.
    function automatic logic [CW-1:0] countDown(input logic [CW-1:0] value);
        return (value == ZERO_COUNT) ? ZERO_COUNT : value - ONE_COUNT;
    endfunction : countDown

    ////////////////////////////////////////////////////////////////////////////
    logic buttonLevel;
    logic buttonFall;
    logic resetButtonLevel;
    logic goodLevel;
    logic supplyLevel;

    pin_synchronizer #(.RESET_LEVEL(1'b1)) syncButton (
        .sys_clk(sys_clk), .rst(rst), .pinIn(power_button_n),
        .pinOut(buttonLevel), .pinFall(buttonFall)
    );
    pin_synchronizer #(.RESET_LEVEL(1'b1)) syncResetButton (
        .sys_clk(sys_clk), .rst(rst), .pinIn(reset_button_n),
        .pinOut(resetButtonLevel), .pinFall()
    );
    pin_synchronizer #(.RESET_LEVEL(1'b0)) syncGood (
        .sys_clk(sys_clk), .rst(rst), .pinIn(power_good),
        .pinOut(goodLevel), .pinFall()
    );
    pin_synchronizer #(.RESET_LEVEL(1'b0)) syncSupply (
        .sys_clk(sys_clk), .rst(rst), .pinIn(main_supply_input),
        .pinOut(supplyLevel), .pinFall()
    );

    ////////////////////////////////////////////////////////////////////////////
    power_reset_pkg::power_state_type state;
    power_reset_pkg::power_state_type next_state;
    logic [CW-1:0] holdCount;
    logic [CW-1:0] leadCount;
    logic warning;

    // Any active source; watchdog and software come from same-clock logic.
    wire resetSource = ~resetButtonLevel | ~goodLevel | ~supplyLevel
                       | watchdog_timeout | software_reset; // [R7] [R3] [R5] [R8]
    wire holdDone = (holdCount == ZERO_COUNT);
    wire leadDone = warning && (leadCount == ZERO_COUNT);
    wire next_reset_n = ~resetSource & holdDone & (next_state != power_reset_pkg::PWR_OFF);

    always_comb begin
        next_state = state;
        unique case (state)
            power_reset_pkg::PWR_OFF: begin
                if (buttonFall) begin
                    next_state = power_reset_pkg::PWR_STARTUP; // [R2]
                end
            end
            power_reset_pkg::PWR_STARTUP: begin
                if (goodLevel && supplyLevel) begin
                    next_state = power_reset_pkg::PWR_RUNNING; // [R9]
                end
            end
            power_reset_pkg::PWR_RUNNING: begin
                if (buttonFall) begin
                    next_state = power_reset_pkg::PWR_OFF; // [R2]
                end else if (leadDone) begin
                    next_state = power_reset_pkg::PWR_SUSPEND; // [R11]
                end
            end
            power_reset_pkg::PWR_SUSPEND: begin
                if (buttonFall) begin
                    next_state = power_reset_pkg::PWR_STARTUP; // [R2]
                end
            end
        endcase
        // Losing power-good drops any powered state back to waiting for it.
        if (!goodLevel && state != power_reset_pkg::PWR_OFF) begin
            next_state = power_reset_pkg::PWR_STARTUP; // [R5]
        end
    end

    wire startWarning = (state == power_reset_pkg::PWR_RUNNING) && suspend_request
                        && !warning && !buttonFall;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state <= power_reset_pkg::PWR_OFF;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst || resetSource || state == power_reset_pkg::PWR_OFF) begin
            holdCount <= HOLD_COUNT; // [R10]
        end else if (!holdDone) begin
            holdCount <= countDown(holdCount);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst || state != power_reset_pkg::PWR_RUNNING || buttonFall) begin
            warning <= 1'b0;
            leadCount <= ZERO_COUNT;
        end else if (startWarning) begin
            warning <= 1'b1; // [R11]
            leadCount <= countDown(LEAD_COUNT);
        end else if (warning && !leadDone) begin
            leadCount <= countDown(leadCount);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            power_button_event <= 1'b0;
            carrier_reset_out_n <= 1'b0;
            suspend_imminent_n <= 1'b1;
            system_running <= 1'b0;
            system_suspended <= 1'b0;
        end else begin
            power_button_event <= buttonFall; // [R1]
            carrier_reset_out_n <= next_reset_n; // [R6] [R10]
            suspend_imminent_n <= ~(startWarning | (warning & ~leadDone));
            system_running <= (next_state == power_reset_pkg::PWR_RUNNING);
            system_suspended <= (next_state == power_reset_pkg::PWR_SUSPEND);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    // Cycles since the last reset source or off state, kept for the hold check.
    logic [CW-1:0] quietCount;
    wire [CW-1:0] next_quietCount = (quietCount == FULL_COUNT) ? quietCount
                                    : quietCount + ONE_COUNT;

    always_ff @(posedge sys_clk) begin
        if (rst || resetSource || state == power_reset_pkg::PWR_OFF) begin
            quietCount <= ZERO_COUNT;
        end else begin
            quietCount <= next_quietCount;
        end
    end

    a_event_follows_fall: assert property ( // [R1]
        buttonFall |=> power_button_event)
        else $error("Power button event missing after falling edge.");
    a_event_only_on_fall: assert property ( // [R1]
        power_button_event |-> $past(buttonFall))
        else $error("Power button event without falling edge.");
    a_reset_button_resets: assert property ( // [R3]
        !resetButtonLevel |=> !carrier_reset_out_n)
        else $error("Reset button low did not assert carrier reset.");
    a_good_low_resets: assert property ( // [R7]
        (!goodLevel || !supplyLevel || watchdog_timeout || software_reset)
        |=> !carrier_reset_out_n)
        else $error("Reset source active but carrier reset released.");
    a_startup_waits_good: assert property ( // [R9]
        (state == power_reset_pkg::PWR_STARTUP && !goodLevel)
        |=> state != power_reset_pkg::PWR_RUNNING)
        else $error("Startup left before power-good.");
    a_good_drop_recovers: assert property ( // [R5]
        (!goodLevel && state != power_reset_pkg::PWR_OFF)
        |=> state == power_reset_pkg::PWR_STARTUP)
        else $error("Power-good drop did not recover the module.");
    a_reset_hold_time: assert property ( // [R10]
        $rose(carrier_reset_out_n) |-> $past(!resetSource, 2) && $past(!resetSource, 3))
        else $error("Carrier reset released too early.");
    a_off_press_wakes: assert property ( // [R2]
        (state == power_reset_pkg::PWR_OFF && buttonFall)
        |=> state == power_reset_pkg::PWR_STARTUP)
        else $error("Button event did not wake the system.");
    a_warn_before_suspend: assert property ( // [R11]
        $rose(system_suspended) |-> $past(!suspend_imminent_n))
        else $error("Suspend without prior warning.");
    a_reset_in_off: assert property ( // [R6]
        (state == power_reset_pkg::PWR_OFF) |=> !carrier_reset_out_n)
        else $error("Carrier reset released while off.");
    a_reset_hold_count: assert property ( // [R10]
        $rose(carrier_reset_out_n) |-> $past(quietCount) >= HOLD_COUNT)
        else $error("Carrier reset released before the hold time.");
    a_warn_lead_time: assert property ( // [R11]
        $rose(system_suspended) |-> !$past(suspend_imminent_n, LEAD_CYCLES))
        else $error("Suspend warning shorter than the lead time.");
    a_warn_only_running: assert property ( // [R11]
        (state != power_reset_pkg::PWR_RUNNING) [*2] |=> suspend_imminent_n)
        else $error("Suspend warning outside the running state.");
    a_startup_ignores_button: assert property ( // [R2]
        (state == power_reset_pkg::PWR_STARTUP && buttonFall)
        |=> state != power_reset_pkg::PWR_OFF)
        else $error("Button press during startup was not ignored.");

    c_wake: cover property (
        state == power_reset_pkg::PWR_OFF ##1 state == power_reset_pkg::PWR_STARTUP);
    c_run: cover property ($rose(carrier_reset_out_n));
    c_suspend: cover property ($rose(system_suspended));
    c_startup_press: cover property (
        state == power_reset_pkg::PWR_STARTUP && buttonFall);
    c_shutdown: cover property (
        state == power_reset_pkg::PWR_RUNNING ##1 state == power_reset_pkg::PWR_OFF);
endmodule : module_power_reset_control

// ==== verification/carrier_board_model.sv ====
// Carrier board model: buttons, main supply and power-good line.
`timescale 1ns/1ps
module carrier_board_model (
    input wire logic pressPower,
    input wire logic pressReset,
    input wire logic programming,
    input wire logic supplyOk,
    output logic power_button_n,
    output logic reset_button_n,
    output logic power_good,
    output logic main_supply_input
);
    // Buttons are debounced on the board, so each press is one clean edge.
    assign power_button_n = !pressPower;
    assign reset_button_n = !pressReset;
    // Power-good stays low while board logic is still being programmed.
    assign power_good = supplyOk && !programming;
    assign main_supply_input = supplyOk;
endmodule : carrier_board_model

// ==== verification/module_power_reset_control_test.sv ====
// Self-checking bench for the module power and reset control block.
`timescale 1ns/1ps
module module_power_reset_control_test;
    localparam int HOLD = 4;
    localparam int LEAD = 3;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic pressPower = 1'b0;
    logic pressReset = 1'b0;
    logic programming = 1'b0;
    logic supplyOk = 1'b1;
    logic watchdogTimeout = 1'b0;
    logic softwareReset = 1'b0;
    logic suspendRequest = 1'b0;
    logic powerButtonN, resetButtonN, powerGood, mainSupply;
    logic buttonEvent, carrierResetN, suspendImminentN, running, suspended;
    int miscompares = 0;
    int compares = 0;
    int took;
    carrier_board_model board (.pressPower(pressPower), .pressReset(pressReset),
        .programming(programming), .supplyOk(supplyOk), .power_button_n(powerButtonN),
        .reset_button_n(resetButtonN), .power_good(powerGood), .main_supply_input(mainSupply));
    module_power_reset_control #(.HOLD_CYCLES(HOLD), .LEAD_CYCLES(LEAD)) dut (
        .sys_clk(sys_clk), .rst(rst), .power_button_n(powerButtonN),
        .reset_button_n(resetButtonN), .power_good(powerGood), .main_supply_input(mainSupply),
        .watchdog_timeout(watchdogTimeout), .software_reset(softwareReset),
        .suspend_request(suspendRequest), .power_button_event(buttonEvent),
        .carrier_reset_out_n(carrierResetN), .suspend_imminent_n(suspendImminentN),
        .system_running(running), .system_suspended(suspended));
    function automatic logic outSel(input int which);
        case (which)
            0: return buttonEvent;
            1: return carrierResetN;
            2: return suspendImminentN;
            3: return running;
            default: return suspended;
        endcase
    endfunction : outSel
    task automatic check(input logic seen, input logic expected, input string what);
        compares++;
        if (seen !== expected) begin
            miscompares++;
            $display("CHECK FAILED at %0t: %s", $time, what);
        end
    endtask : check
    task automatic cycles(input int n);
        repeat (n) begin
            @(posedge sys_clk);
            #1;
        end
    endtask : cycles
    // Counts cycles until an output reaches the level, giving up at the limit.
    task automatic waitOut(input int which, input logic level, input int limit);
        took = 0;
        while (outSel(which) !== level && took < limit) begin
            cycles(1);
            took++;
        end
    endtask : waitOut
    task automatic pressPowerButton();
        pressPower = 1'b1;
        waitOut(0, 1'b1, 10);
        check(took < 10, 1'b1, "no button event");
        cycles(1);
        check(buttonEvent, 1'b0, "event too long");
        cycles(6);
        pressPower = 1'b0;
        cycles(6);
    endtask : pressPowerButton
    task automatic releaseCheck();
        waitOut(1, 1'b1, HOLD + 12);
        check(took >= HOLD - 1 && took < HOLD + 12, 1'b1, "reset release time");
    endtask : releaseCheck
    task automatic startupHeld();
        programming = 1'b1;
        pressPowerButton();
        cycles(20);
        check(running, 1'b0, "started before power good");
        check(carrierResetN, 1'b0, "reset released early");
        pressPowerButton();
        check(running, 1'b0, "press in startup left startup");
        programming = 1'b0;
        waitOut(3, 1'b1, 8);
        check(running, 1'b1, "no startup");
        releaseCheck();
    endtask : startupHeld
    task automatic setSource(input int s, input logic v);
        case (s)
            0: watchdogTimeout = v;
            1: softwareReset = v;
            2: pressReset = v;
            3: programming = v;
            default: supplyOk = !v;
        endcase
    endtask : setSource
    task automatic resetSources();
        for (int s = 0; s < 5; s++) begin
            setSource(s, 1'b1);
            waitOut(1, 1'b0, 8);
            check(took < 8, 1'b1, "reset not asserted");
            cycles(10);
            check(carrierResetN, 1'b0, "reset dropped early");
            setSource(s, 1'b0);
            releaseCheck();
            waitOut(3, 1'b1, 10);
            check(running, 1'b1, "not running after source");
        end
    endtask : resetSources
    task automatic suspendWake();
        suspendRequest = 1'b1;
        waitOut(2, 1'b0, 3);
        check(suspendImminentN, 1'b0, "no suspend warning");
        waitOut(2, 1'b1, LEAD + 4);
        suspendRequest = 1'b0;
        check(took == LEAD, 1'b1, "warning length");
        cycles(1);
        check(suspended, 1'b1, "not suspended");
        pressPowerButton();
        waitOut(3, 1'b1, 10);
        check(running, 1'b1, "no wake");
        pressPowerButton();
        check(running, 1'b0, "no power down");
        check(carrierResetN, 1'b0, "reset not held when off");
        suspendRequest = 1'b1;
        cycles(6);
        check(suspendImminentN, 1'b1, "warning while off");
        check(suspended, 1'b0, "suspended from off");
        suspendRequest = 1'b0;
    endtask : suspendWake
    task automatic powerCycle();
        pressPowerButton();
        waitOut(3, 1'b1, 10);
        check(running, 1'b1, "no start before power cycle");
        rst = 1'b1;
        cycles(4);
        check(carrierResetN, 1'b0, "reset out in power cycle");
        check(running, 1'b0, "running in power cycle");
        rst = 1'b0;
        cycles(4);
        check(running, 1'b0, "running after power cycle");
        check(carrierResetN, 1'b0, "reset out after power cycle");
        pressPowerButton();
        waitOut(3, 1'b1, 10);
        check(running, 1'b1, "no start after power cycle");
        check(carrierResetN, 1'b1, "reset held after restart");
    endtask : powerCycle
    task automatic wrap_up();
        $display("Checks made %0d, mismatches %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : wrap_up
    initial begin
        forever #25 sys_clk = ~sys_clk;
    end
    initial begin
        #(20000 * 50);
        miscompares++;
        wrap_up();
    end
    initial begin
        cycles(12);
        check(carrierResetN, 1'b0, "reset out in reset");
        check(suspendImminentN, 1'b1, "warning in reset");
        check(buttonEvent, 1'b0, "event in reset");
        check(running, 1'b0, "running in reset");
        check(suspended, 1'b0, "suspended in reset");
        rst = 1'b0;
        cycles(4);
        startupHeld();
        resetSources();
        suspendWake();
        powerCycle();
        wrap_up();
    end
endmodule : module_power_reset_control_test
